// [rtl/tpq_pkg.sv]
// Purpose: shared constants for the tap pulse qualifier
// Assumes: byte-wide register port, 40 MHz core clock
// Notes: step shift codes scale a base time step of 0.625 ms by powers of two
package tpq_pkg;
    localparam logic [7:0] TPQ_OFS_XTHR = 8'h23;
    localparam logic [7:0] TPQ_OFS_YTHR = 8'h24;
    localparam logic [7:0] TPQ_OFS_ZTHR = 8'h25;
    localparam logic [7:0] TPQ_OFS_TLIM = 8'h26;
    localparam logic [7:0] TPQ_OFS_IGN = 8'h27;
    localparam logic [6:0] TPQ_THR_RESET = 7'h00;
    localparam logic [7:0] TPQ_TLIM_RESET = 8'h00;
    localparam logic [7:0] TPQ_IGN_RESET = 8'h00;
    localparam int TPQ_THR_MSB = 6;
    localparam logic [6:0] TPQ_LN_MAX_THR = 7'h3F;
    // base step 0.625 ms at 40 MHz
    localparam int TPQ_CLK_KHZ = 40000;
    localparam int TPQ_BASE_STEP_US = 625;
    localparam int TPQ_BASE_STEP_CYC = TPQ_BASE_STEP_US * TPQ_CLK_KHZ / 1000;
    // rate codes: 0=800,1=400,2=200,3=100,4=50,5=12.5,6=6.25,7=1.56 Hz
    typedef enum logic [1:0] {
        TPQ_MODE_NORMAL = 2'h0,
        TPQ_MODE_LNLP = 2'h1,
        TPQ_MODE_HIRES = 2'h2,
        TPQ_MODE_LOWPWR = 2'h3
    } tpq_mode_t;
    typedef enum logic [1:0] {
        TPQ_ST_IDLE = 2'h0,
        TPQ_ST_ABOVE = 2'h1,
        TPQ_ST_IGNORE = 2'h3
    } tpq_state_t;
endpackage

// [rtl/tpq_step_timer.sv]
// Purpose: time-step tick generator
// Assumes: step shift selects 0.625 ms * 2^shift
// Notes: restarts whenever the step selection changes
`timescale 1ns/1ps
module tpq_step_timer import tpq_pkg::*; #(
    parameter int BASE_CYC = TPQ_BASE_STEP_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] stepShift,
    output logic tick
);
    localparam int CW = 24;
    logic [CW-1:0] cnt_q, cnt_d, limit;
    logic [3:0] shift_q;
    logic tick_d;

    always_comb begin
        limit = CW'(BASE_CYC) << stepShift;
        tick_d = 1'b0;
        cnt_d = cnt_q + CW'(1);
        if (shift_q != stepShift) begin
            cnt_d = '0;
        end else if (cnt_q >= limit - CW'(1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
            shift_q <= 4'h0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            shift_q <= stepShift;
            tick <= tick_d;
        end
    end
endmodule // tpq_step_timer

// [rtl/tpq_tap_qualifier.sv]
// Purpose: per-axis tap pulse qualification with threshold and time limit
// Assumes: magnitudes arrive already filtered, in 0.063 g codes, each clock
// Notes: one shared step tick drives the time-limit and ignore counters
//
// Functional notes
// - each axis has its own start threshold and arms on crossing it.
// - thresholds are 7-bit unsigned in bits 6..0, bit 7 reads zero.
// - codes 1..127 weigh 0.063 g each on a fixed 8 g scale.
// - with low-noise set the usable threshold is capped at 4 g.
// - a pulse is valid only if it falls below threshold before the limit.
// - the time limit is an 8-bit count of steps, at most 255 steps.
// - step length depends on rate, oversampling mode and tap lowpass enable.
// - with lowpass on steps run 1.25 ms at 800 Hz and, outside high-res, double per rate halving down to 50 Hz.
// - with lowpass off steps are a quarter of the lowpass-on step, but half at 800 Hz and in low-power mode down to 12.5 Hz.
// - threshold registers reset to zero, leaving no axis armed.
// - the time-limit register resets to zero.
// - after a first pulse all pulses are ignored for the ignore interval.
`timescale 1ns/1ps
module tpq_tap_qualifier import tpq_pkg::*; #(
    parameter int BASE_CYC = TPQ_BASE_STEP_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRvalid,
    input wire logic [2:0] outputSampleRate,
    input wire logic [1:0] oversampleMode,
    input wire logic tapLowpassEnable,
    input wire logic lowNoiseEnable,
    input wire logic [7:0] magX,
    input wire logic [7:0] magY,
    input wire logic [7:0] magZ,
    output logic [2:0] pulseValid,
    output logic [2:0] axisActive,
    output logic ignoreActive
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [6:0] thr_q [3];
    logic [6:0] thr_d [3];
    logic [7:0] tlim_q, tlim_d, ign_q, ign_d;
    logic [7:0] rdata_d;
    logic rvalid_d;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            thr_d[i] = thr_q[i];
        end
        tlim_d = tlim_q;
        ign_d = ign_q;
        if (regWrite) begin
            unique case (regAddr)
                TPQ_OFS_XTHR: thr_d[0] = regWdata[TPQ_THR_MSB:0];
                TPQ_OFS_YTHR: thr_d[1] = regWdata[TPQ_THR_MSB:0];
                TPQ_OFS_ZTHR: thr_d[2] = regWdata[TPQ_THR_MSB:0];
                TPQ_OFS_TLIM: tlim_d = regWdata;
                TPQ_OFS_IGN: ign_d = regWdata;
                default: ;
            endcase
        end
        rvalid_d = regRead;
        unique case (regAddr)
            TPQ_OFS_XTHR: rdata_d = {1'b0, thr_q[0]};
            TPQ_OFS_YTHR: rdata_d = {1'b0, thr_q[1]};
            TPQ_OFS_ZTHR: rdata_d = {1'b0, thr_q[2]};
            TPQ_OFS_TLIM: rdata_d = tlim_q;
            TPQ_OFS_IGN: rdata_d = ign_q;
            default: rdata_d = 8'h00;
        endcase
        if (!regRead) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                thr_q[i] <= TPQ_THR_RESET;
            end
            tlim_q <= TPQ_TLIM_RESET;
            ign_q <= TPQ_IGN_RESET;
            regRdata <= 8'h00;
            regRvalid <= 1'b0;
        end else begin
            thr_q <= thr_d;
            tlim_q <= tlim_d;
            ign_q <= ign_d;
            regRdata <= rdata_d;
            regRvalid <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time step selection: shift over 0.625 ms
    // 50 Hz to 12.5 Hz is a fourfold step, so rate codes are not plain doublings
    function automatic logic [3:0] stepShiftOf(input logic [2:0] rate,
                                               input logic [1:0] mode,
                                               input logic lpf);
        logic [3:0] s;
        // lowpass on: one doubling per rate code up to 50 Hz
        s = (rate > 3'h4) ? 4'h5 : {1'b0, rate} + 4'h1;
        unique case (mode)
            TPQ_MODE_NORMAL: ;
            TPQ_MODE_LNLP: s = (rate > 3'h4) ? 4'h7 : s;
            TPQ_MODE_HIRES: s = (rate == 3'h0) ? 4'h1 : 4'h2;
            TPQ_MODE_LOWPWR: s = (rate > 3'h5) ? 4'h8 : ((rate == 3'h5) ? 4'h7 : s);
        endcase
        // lowpass off is not a plain half at slow rates
        if (!lpf && mode == TPQ_MODE_LOWPWR) begin
            s = (s > 4'h7) ? 4'h6 : s - 4'h1;
        end else if (!lpf) begin
            s = (s > 4'h2) ? s - 4'h2 : 4'h0;
        end
        stepShiftOf = s;
    endfunction

    logic stepTick;
    logic [3:0] stepShift;
    assign stepShift = stepShiftOf(outputSampleRate, oversampleMode, tapLowpassEnable);

    tpq_step_timer #(.BASE_CYC(BASE_CYC)) u_timer (
        .clk(clk),
        .reset(reset),
        .stepShift(stepShift),
        .tick(stepTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-axis qualification
    function automatic logic [6:0] effThr(input logic [6:0] t, input logic ln);
        effThr = (ln && t > TPQ_LN_MAX_THR) ? TPQ_LN_MAX_THR : t;
    endfunction

    tpq_state_t st_q [3];
    tpq_state_t st_d [3];
    logic [7:0] cnt_q [3];
    logic [7:0] cnt_d [3];
    logic [7:0] icnt_q, icnt_d;
    logic ign_act_q, ign_act_d;
    logic [2:0] valid_d, active_d;
    logic [7:0] mag [3];
    logic [6:0] t;
    logic above;

    assign mag[0] = magX;
    assign mag[1] = magY;
    assign mag[2] = magZ;

    always_comb begin
        valid_d = 3'h0;
        active_d = 3'h0;
        icnt_d = icnt_q;
        ign_act_d = ign_act_q;
        t = 7'h00;
        above = 1'b0;
        if (ign_act_q && stepTick) begin
            if (icnt_q >= ign_q) begin
                ign_act_d = 1'b0;
            end else begin
                icnt_d = icnt_q + 8'h01;
            end
        end
        for (int i = 0; i < 3; i++) begin
            st_d[i] = st_q[i];
            cnt_d[i] = cnt_q[i];
            t = effThr(thr_q[i], lowNoiseEnable);
            // zero code never arms
            above = (t != 7'h00) && (mag[i] > {1'b0, t});
            unique case (st_q[i])
                TPQ_ST_IDLE: begin
                    if (above && !ign_act_q) begin
                        st_d[i] = TPQ_ST_ABOVE;
                        cnt_d[i] = 8'h00;
                    end
                end
                TPQ_ST_ABOVE: begin
                    if (!above) begin
                        st_d[i] = TPQ_ST_IDLE;
                        // a pulse ending inside the ignore interval is dropped
                        if (cnt_q[i] < tlim_q && !ign_act_q) begin
                            valid_d[i] = 1'b1;
                        end
                    end else if (stepTick && cnt_q[i] != 8'hFF) begin
                        cnt_d[i] = cnt_q[i] + 8'h01;
                    end
                    if (cnt_q[i] >= tlim_q) begin
                        st_d[i] = TPQ_ST_IGNORE;
                    end
                end
                TPQ_ST_IGNORE: begin
                    // too long: wait for the signal to drop before rearming
                    if (!above) begin
                        st_d[i] = TPQ_ST_IDLE;
                    end
                end
                default: st_d[i] = TPQ_ST_IDLE;
            endcase
            active_d[i] = (st_d[i] == TPQ_ST_ABOVE);
        end
        if (valid_d != 3'h0 && !ign_act_q) begin
            ign_act_d = 1'b1;
            icnt_d = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                st_q[i] <= TPQ_ST_IDLE;
                cnt_q[i] <= 8'h00;
            end
            icnt_q <= 8'h00;
            ign_act_q <= 1'b0;
            pulseValid <= 3'h0;
            axisActive <= 3'h0;
            ignoreActive <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            icnt_q <= icnt_d;
            ign_act_q <= ign_act_d;
            pulseValid <= valid_d;
            axisActive <= active_d;
            ignoreActive <= ign_act_d;
        end
    end
endmodule // tpq_tap_qualifier

// [tb/tpq_host_model.sv]
// Purpose: host side of the register port
// Assumes: requests change on the falling edge
// Notes: a released data bus shows the inverse value
`timescale 1ns/1ps
module tpq_host_model (
    input wire logic clk,
    output logic regWrite = 1'b0,
    output logic regRead = 1'b0,
    output logic [7:0] regAddr = 8'h00,
    output logic [7:0] regWdata = 8'h00,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regWdata = ~d;
    endtask
    // bounded wait, answer taken while it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        d = 8'hEE;
        for (int i = 0; i < 3; i++) begin
            if (regRvalid === 1'b1) d = regRdata;
            @(negedge clk);
        end
    endtask
endmodule // tpq_host_model

// [tb/tpq_tap_qualifier_asserts.sv]
// Purpose: port checker for the tap qualifier
// Assumes: one clock, synchronous reset
// Notes: bound to every qualifier instance
`timescale 1ns/1ps
module tpq_tap_qualifier_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid,
    input wire logic [2:0] pulseValid,
    input wire logic [2:0] axisActive,
    input wire logic ignoreActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////
    property p_ans;
        regRead |=> regRvalid;
    endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_idle;
        !regRvalid |-> regRdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data without valid");
    property p_bit7;
        regRvalid && $past(regAddr) inside {8'h23, 8'h24, 8'h25} |-> !regRdata[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("threshold bit 7 set");
    property p_unmap;
        regRvalid && !($past(regAddr) inside {[8'h23:8'h27]}) |-> regRdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_cause;
        |pulseValid |-> (pulseValid & ~$past(axisActive)) == 3'h0;
    endproperty
    a_cause: assert property (p_cause) else $error("pulse without active axis");
    property p_once;
        |pulseValid |=> pulseValid == 3'h0;
    endproperty
    a_once: assert property (p_once) else $error("pulse longer than one cycle");
    property p_ign;
        |pulseValid |-> ##[0:1] ignoreActive;
    endproperty
    a_ign: assert property (p_ign) else $error("no ignore after pulse");
    property p_quiet;
        |pulseValid |-> !$past(ignoreActive);
    endproperty
    a_quiet: assert property (p_quiet) else $error("pulse during ignore");
    // first ignore cycle excluded: start may share the opening edge
    property p_block;
        $past(ignoreActive) && ignoreActive |-> (axisActive & ~$past(axisActive)) == 3'h0;
    endproperty
    a_block: assert property (p_block) else $error("start during ignore");
    cover property (pulseValid[0]);
    cover property (pulseValid[2]);
    cover property (ignoreActive && axisActive == 3'h0);
endmodule // tpq_tap_qualifier_asserts
bind tpq_tap_qualifier tpq_tap_qualifier_asserts chk (.clk, .reset, .regRead, .regAddr,
    .regRdata, .regRvalid, .pulseValid, .axisActive, .ignoreActive);

// [tb/tpq_tap_qualifier_tb.sv]
// Purpose: self-checking bench for the tap qualifier
// Assumes: step base of 4 cycles, limit 3 steps
// Notes: tap widths keep a one-step margin to the limit
`timescale 1ns/1ps
module tpq_tap_qualifier_tb;
    import tpq_pkg::*;
    logic clk, reset, regWrite, regRead, regRvalid, lpf, lowNoise, ignoreActive;
    logic [7:0] regAddr, regWdata, regRdata, rd;
    logic [2:0][7:0] mag;
    logic [2:0] pulseValid, axisActive;
    logic [2:0] rate;
    logic [1:0] osMode;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    tpq_tap_qualifier #(.BASE_CYC(4)) uut (.clk, .reset, .regWrite, .regRead, .regAddr,
        .regWdata, .regRdata, .regRvalid, .outputSampleRate(rate), .oversampleMode(osMode),
        .tapLowpassEnable(lpf), .lowNoiseEnable(lowNoise), .magX(mag[0]), .magY(mag[1]),
        .magZ(mag[2]), .pulseValid, .axisActive, .ignoreActive);
    tpq_host_model host (.clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
        .regRvalid);
    ////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // re-raise after the pulse: must not start while ignoring
    task automatic tap(input int ax, input int hi, input logic [2:0] exp);
        logic [2:0] seen;
        seen = 3'h0;
        mag[ax] = 8'h45;
        repeat (hi) @(negedge clk);
        mag[ax] = 8'h00;
        repeat (8) begin
            @(negedge clk);
            seen |= pulseValid;
        end
        check("pulseValid", {5'h0, seen}, {5'h0, exp});
        mag[ax] = 8'h45;
        repeat (2) @(negedge clk);
        if (ignoreActive === 1'b1) check("axisActive", {5'h0, axisActive}, 8'h00);
        mag[ax] = 8'h00;
        for (int i = 0; i < 1000 && (ignoreActive !== 1'b0 || axisActive !== 3'h0); i++)
            @(negedge clk);
        $display("test tap axis %0d width %0d done", ax, hi);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        lpf = 1'b0;
        lowNoise = 1'b0;
        rate = 3'h0;
        osMode = 2'h0;
        mag = '0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 5; i++) begin
            host.rd(TPQ_OFS_XTHR + 8'(i), rd);
            check("reset value", rd, 8'h00);
        end
        host.rd(8'h28, rd);
        check("unmapped", rd, 8'h00);
        host.wr(TPQ_OFS_XTHR, 8'hFF);
        host.rd(TPQ_OFS_XTHR, rd);
        check("threshold", rd, 8'h7F);
        host.wr(TPQ_OFS_TLIM, 8'h03);
        host.wr(TPQ_OFS_IGN, 8'h05);
        host.rd(TPQ_OFS_TLIM, rd);
        check("limit", rd, 8'h03);
        host.rd(TPQ_OFS_IGN, rd);
        check("ignore", rd, 8'h05);
        $display("test registers done");
        tap(1, 6, 3'h0);
        for (int a = 0; a < 3; a++) begin
            host.wr(TPQ_OFS_XTHR + 8'(a), 8'h10);
            tap(a, 6, 3'h1 << a);
        end
        tap(0, 30, 3'h0);
        lpf = 1'b1;
        tap(0, 16, 3'h1);
        lpf = 1'b0;
        tap(0, 16, 3'h0);
        host.wr(TPQ_OFS_XTHR, 8'h50);
        tap(0, 6, 3'h0);
        lowNoise = 1'b1;
        tap(0, 6, 3'h1);
        // high-res keeps 2.5 ms below 800 Hz: 16-cycle steps, 30 cycles fit
        rate = 3'h3;
        osMode = TPQ_MODE_HIRES;
        lpf = 1'b1;
        tap(0, 30, 3'h1);
        // low-noise-low-power at 12.5 Hz, lowpass off: 128-cycle steps
        rate = 3'h5;
        osMode = TPQ_MODE_LNLP;
        lpf = 1'b0;
        tap(0, 200, 3'h1);
        tally_and_finish();
    end
endmodule // tpq_tap_qualifier_tb
